// *** scan_jump_regs.svh ***
`ifndef SCAN_JUMP_REGS_SVH
`define SCAN_JUMP_REGS_SVH

// Byte addresses of the register window.
`define ADDR_CMD        8'h00
`define ADDR_JUMP_LIT   8'h04
`define ADDR_STATUS     8'h08
`define ADDR_PC         8'h0C
`define REGION_WORK     2'b01
`define REGION_DMEM     2'b10

// Command word fields.
`define CMD_OP_LSB      0
`define CMD_SRC_LSB     4
`define CMD_MODE_LSB    8
`define CMD_DST_LSB     11
`define CMD_BYTE_BIT    15
`define CMD_TOFILE_BIT  16
`define CMD_FADDR_LSB   17

// Status word fields.
`define ST_C_BIT        0
`define ST_Z_BIT        1
`define ST_OVF_BIT      2
`define ST_N_BIT        3
`define ST_DIGIT_BIT    8
`define ST_BUSY_BIT     16
`define ST_FLUSH_BIT    17

// Reset values and constants.
`define PC_RESET        23'h00_0000
`define NO_SIGN_CHANGE  16'hFFF1
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// *** scan_jump_pkg.sv ***
package scan_jump_pkg;

    typedef enum logic [2:0] {
        OP_NONE, OP_SIGN_LEFT, OP_ONE_LEFT, OP_ONE_RIGHT,
        OP_INC_FILE, OP_JUMP_LIT, OP_JUMP_REG
    } op_t;

    typedef enum logic [2:0] {
        AM_DIRECT, AM_IND, AM_POST_INC, AM_POST_DEC, AM_PRE_INC, AM_PRE_DEC
    } addr_mode_t;

    typedef enum logic {
        JS_IDLE, JS_LOAD
    } jump_state_t;

    typedef struct packed {
        logic [15:0][15:0] default_working_reg;
        logic [15:0][15:0] dmem;
        logic [22:0]       pc;
        logic [22:0]       jump_lit;
        logic [22:0]       jtarget;
        jump_state_t       jstate;
        logic              flush;
        logic              c;
        logic              z;
        logic              overflow;
        logic              n;
        logic              digit_carry;
        logic [7:0]        aw_addr;
        logic              aw_have;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              w_have;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } state_t;

endpackage : scan_jump_pkg

// *** bit_scan_increment_jump_unit.sv ***
`timescale 1ns/10ps
`include "scan_jump_regs.svh"

module bit_scan_increment_jump_unit
    import scan_jump_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [22:0]      pc_value,
    output logic             fetch_flush
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [16:0] scan_one_from_left(input logic [15:0] w);
        logic [15:0] r;
        logic        f;
        r = 16'h0000;
        f = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (!f && w[15 - i]) begin
                r = 16'(i + 1);
                f = 1'b1;
            end
        end
        return {!f, r};
    endfunction : scan_one_from_left

    function automatic logic [16:0] scan_one_from_right(input logic [15:0] w);
        logic [15:0] r;
        logic        f;
        r = 16'h0000;
        f = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (!f && w[i]) begin
                r = 16'(i + 1);
                f = 1'b1;
            end
        end
        return {!f, r};
    endfunction : scan_one_from_right

    function automatic logic [16:0] scan_sign_change_left(input logic [15:0] w);
        logic [15:0] r;
        logic        f;
        r = `NO_SIGN_CHANGE;
        f = 1'b0;
        for (int i = 0; i < 15; i++) begin
            if (!f && (w[14 - i] != w[15])) begin
                r = 16'h0000 - 16'(i);
                f = 1'b1;
            end
        end
        return {!f, r};
    endfunction : scan_sign_change_left

    // Returns {digit carry, negative, overflow, zero, carry, sum}; a byte sum sits in the low 8 bits.
    function automatic logic [20:0] increment(input logic [15:0] a, input logic byte_op);
        logic [16:0] s;
        logic [15:0] r;
        s = {1'b0, a} + 17'h0_0001;
        if (byte_op) begin
            r = {8'h00, s[7:0]};
            return {a[3:0] == 4'hF, r[7], a[7:0] == 8'h7F, r[7:0] == 8'h00, a[7:0] == 8'hFF, r};
        end
        r = s[15:0];
        return {a[7:0] == 8'hFF, r[15], a == 16'h7FFF, r == 16'h0000, s[16], r};
    endfunction : increment

    function automatic op_t decode_op(input logic [3:0] code);
        case (code)
            4'h1: return OP_SIGN_LEFT;
            4'h2: return OP_ONE_LEFT;
            4'h3: return OP_ONE_RIGHT;
            4'h4: return OP_INC_FILE;
            4'h5: return OP_JUMP_LIT;
            4'h6: return OP_JUMP_REG;
            default: return OP_NONE;
        endcase
    endfunction : decode_op

    // Returns {mapped, value} for a register read.
    function automatic logic [32:0] read_reg(input state_t s, input logic [7:0] a);
        if (a[7:6] == `REGION_WORK) begin
            return {1'b1, 16'h0000, s.default_working_reg[a[5:2]]};
        end
        if (a[7:6] == `REGION_DMEM && !a[5]) begin
            return {1'b1, 16'h0000, s.dmem[a[5:2]]};
        end
        case (a)
            `ADDR_CMD:      return {1'b1, 32'h0000_0000};
            `ADDR_JUMP_LIT: return {1'b1, 9'h000, s.jump_lit};
            `ADDR_STATUS: begin
                return {1'b1, 14'h0000, s.flush, s.jstate == JS_LOAD,
                        7'h00, s.digit_carry, 4'h0, s.n, s.overflow, s.z, s.c};
            end
            `ADDR_PC:       return {1'b1, 9'h000, s.pc};
            default:        return {1'b0, 32'h0000_0000};
        endcase
    endfunction : read_reg

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8 * i +: 8] = nw[8 * i +: 8];
            end
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    state_t      s_reg;
    state_t      s_next;
    logic [32:0] rd_old;
    logic [31:0] wv;
    logic [31:0] cmd;
    op_t         op;
    addr_mode_t  mode;
    logic [3:0]  src;
    logic [3:0]  dst;
    logic [15:0] src_word;
    logic [15:0] src_next;
    logic [15:0] opnd;
    logic        src_upd;
    logic [16:0] scan;
    logic [20:0] inc;
    logic [3:0]  fidx;
    logic [15:0] fword;
    logic [32:0] rd_new;

    always_comb begin
        s_next = s_reg;
        rd_old = read_reg(s_reg, s_reg.aw_addr);
        wv     = merge(rd_old[31:0], s_reg.w_data, s_reg.w_strb);
        cmd    = s_reg.w_data;
        op     = decode_op(cmd[`CMD_OP_LSB +: 4]);
        src    = cmd[`CMD_SRC_LSB +: 4];
        dst    = cmd[`CMD_DST_LSB +: 4];
        mode   = addr_mode_t'(cmd[`CMD_MODE_LSB +: 3]);
        src_word = s_reg.default_working_reg[src];
        src_next = src_word;
        src_upd  = 1'b0;
        opnd     = src_word;
        scan   = 17'h0_0000;
        fidx   = cmd[`CMD_FADDR_LSB + 1 +: 4];
        fword  = s_reg.dmem[fidx];
        inc    = 21'h00_0000;
        rd_new = read_reg(s_reg, araddr);

        if (s_reg.awready && awvalid) begin
            s_next.aw_addr = awaddr;
            s_next.aw_have = 1'b1;
        end
        if (s_reg.wready && wvalid) begin
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
            s_next.w_have = 1'b1;
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // Second cycle of a jump: the flushed slot retires and the PC takes the target.
        if (s_reg.jstate == JS_LOAD) begin
            s_next.pc     = s_reg.jtarget;
            s_next.flush  = 1'b0;
            s_next.jstate = JS_IDLE;
        end

        if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = `RESP_OKAY;
            if (!rd_old[32]) begin
                s_next.bresp = `RESP_SLVERR;
            end else if (s_reg.aw_addr[7:6] == `REGION_WORK) begin
                s_next.default_working_reg[s_reg.aw_addr[5:2]] = wv[15:0];
            end else if (s_reg.aw_addr[7:6] == `REGION_DMEM) begin
                s_next.dmem[s_reg.aw_addr[5:2]] = wv[15:0];
            end else if (s_reg.aw_addr == `ADDR_JUMP_LIT) begin
                s_next.jump_lit = wv[22:0];
            end else if (s_reg.aw_addr == `ADDR_STATUS) begin
                s_next.c           = wv[`ST_C_BIT];
                s_next.z           = wv[`ST_Z_BIT];
                s_next.overflow    = wv[`ST_OVF_BIT];
                s_next.n           = wv[`ST_N_BIT];
                s_next.digit_carry = wv[`ST_DIGIT_BIT];
            end else if (s_reg.jstate == JS_LOAD) begin
                // A command or PC write during a jump is refused.
                s_next.bresp = `RESP_SLVERR;
            end else if (s_reg.aw_addr == `ADDR_PC) begin
                s_next.pc = wv[22:0];
            end else if (s_reg.w_strb != 4'hF) begin
                // A command must be written whole.
                s_next.bresp = `RESP_SLVERR;
            end else begin
                // Operand fetch; scans are word-only so the width bit is ignored.
                case (mode)
                    AM_IND: begin
                        opnd = s_reg.dmem[src_word[4:1]];
                    end
                    AM_POST_INC: begin
                        opnd     = s_reg.dmem[src_word[4:1]];
                        src_next = src_word + 16'h0002;
                        src_upd  = 1'b1;
                    end
                    AM_POST_DEC: begin
                        opnd     = s_reg.dmem[src_word[4:1]];
                        src_next = src_word - 16'h0002;
                        src_upd  = 1'b1;
                    end
                    AM_PRE_INC: begin
                        src_next = src_word + 16'h0002;
                        opnd     = s_reg.dmem[src_next[4:1]];
                        src_upd  = 1'b1;
                    end
                    AM_PRE_DEC: begin
                        src_next = src_word - 16'h0002;
                        opnd     = s_reg.dmem[src_next[4:1]];
                        src_upd  = 1'b1;
                    end
                    default: begin
                        opnd = src_word;
                    end
                endcase
                case (op)
                    OP_SIGN_LEFT: scan = scan_sign_change_left(opnd);
                    OP_ONE_LEFT:  scan = scan_one_from_left(opnd);
                    OP_ONE_RIGHT: scan = scan_one_from_right(opnd);
                    default:      scan = 17'h0_0000;
                endcase
                case (op)
                    OP_SIGN_LEFT, OP_ONE_LEFT, OP_ONE_RIGHT: begin
                        if (src_upd) begin
                            s_next.default_working_reg[src] = src_next;
                        end
                        s_next.default_working_reg[dst] = scan[15:0];
                        s_next.c         = scan[16];
                    end
                    OP_INC_FILE: begin
                        if (cmd[`CMD_BYTE_BIT]) begin
                            inc = increment({8'h00, cmd[`CMD_FADDR_LSB] ? fword[15:8] : fword[7:0]},
                                            1'b1);
                        end else begin
                            inc = increment(fword, 1'b0);
                        end
                        {s_next.digit_carry, s_next.n, s_next.overflow, s_next.z, s_next.c} = inc[20:16];
                        if (!cmd[`CMD_TOFILE_BIT] && cmd[`CMD_BYTE_BIT]) begin
                            s_next.default_working_reg[0][7:0] = inc[7:0];
                        end else if (!cmd[`CMD_TOFILE_BIT]) begin
                            s_next.default_working_reg[0] = inc[15:0];
                        end else if (!cmd[`CMD_BYTE_BIT]) begin
                            s_next.dmem[fidx] = inc[15:0];
                        end else if (cmd[`CMD_FADDR_LSB]) begin
                            s_next.dmem[fidx][15:8] = inc[7:0];
                        end else begin
                            s_next.dmem[fidx][7:0] = inc[7:0];
                        end
                    end
                    OP_JUMP_LIT: begin
                        s_next.jtarget = s_reg.jump_lit;
                        s_next.flush   = 1'b1;
                        s_next.jstate  = JS_LOAD;
                    end
                    OP_JUMP_REG: begin
                        s_next.jtarget = {7'h00, src_word[15:1], 1'b0};
                        s_next.flush   = 1'b1;
                        s_next.jstate  = JS_LOAD;
                    end
                    default: begin
                        s_next.bresp = `RESP_SLVERR;
                    end
                endcase
            end
        end

        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd_new[31:0];
            s_next.rresp  = rd_new[32] ? `RESP_OKAY : `RESP_SLVERR;
        end

        s_next.awready = !s_next.aw_have && !s_next.bvalid;
        s_next.wready  = !s_next.w_have && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg    <= '0;
            s_reg.pc <= `PC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign awready     = s_reg.awready;
    assign wready      = s_reg.wready;
    assign bvalid      = s_reg.bvalid;
    assign bresp       = s_reg.bresp;
    assign arready     = s_reg.arready;
    assign rvalid      = s_reg.rvalid;
    assign rdata       = s_reg.rdata;
    assign rresp       = s_reg.rresp;
    assign pc_value    = s_reg.pc;
    assign fetch_flush = s_reg.flush;

endmodule : bit_scan_increment_jump_unit

// *** scan_jump_checker.sv ***
`timescale 1ns/10ps
`include "scan_jump_regs.svh"
module scan_jump_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [22:0] pc_value,
    input wire logic        fetch_flush
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("Write answer dropped early.");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
    a_r_hold: assert property (p_r_hold) else $error("Read answer dropped early.");
    property p_r_lat; arvalid && arready |=> rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("Read answer late.");
    property p_w_lat; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
    a_w_lat: assert property (p_w_lat) else $error("Write answer mistimed.");
    property p_ar_low; rvalid |-> !arready; endproperty
    a_ar_low: assert property (p_ar_low) else $error("Read taken while answering.");
    property p_err_zero; rvalid && rresp == `RESP_SLVERR |-> rdata == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("Refused read carries data.");
    property p_flush_pulse; fetch_flush |=> !fetch_flush; endproperty
    a_flush_pulse: assert property (p_flush_pulse) else $error("Flush too long.");
    property p_flush_cause; fetch_flush |-> $rose(bvalid); endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("Flush without command.");
    property p_pc_cause; $changed(pc_value) |-> $past(fetch_flush) || $rose(bvalid); endproperty
    a_pc_cause: assert property (p_pc_cause) else $error("Program counter moved alone.");
endmodule : scan_jump_checker
bind bit_scan_increment_jump_unit scan_jump_checker chk_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pc_value(pc_value), .fetch_flush(fetch_flush)
);

// *** axil_master_model.sv ***
`timescale 1ns/10ps
module axil_master_model (
    input  wire logic        aclk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // When set, the answer is left waiting three cycles before ready rises.
    logic slow = 1'b0;
    initial begin
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~awaddr;
            end
            if (wready) begin
                wvalid <= 1'b0;
                wdata  <= ~wdata;
            end
        end while (awvalid && !awready || wvalid && !wready);
        if (slow) repeat (3) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr  <= ~a;
        if (slow) repeat (3) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : axil_master_model

// *** testbench.sv ***
`timescale 1ns/10ps
`include "scan_jump_regs.svh"
module testbench;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, fetch_flush;
    logic [1:0]  bresp, rresp, rr;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr;
    logic [22:0] pc_value, lit;
    logic [31:0] wdata, rdata, rv, e;
    logic [16:0] s;
    logic [15:0] w;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, flush_cnt = 0, fl0;
    integer      seed = 30893;
    logic [15:0] corner [8] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h8000, 16'h55FF, 16'hFF0A, 16'h000A, 16'h4000};
    logic [15:0] icorner [4] = '{16'h7FFF, 16'h12FF, 16'h00FF, 16'h347F};
    int          mres [6] = '{2, 5, 5, 5, 9, 1};
    int          mptr [6] = '{2, 2, 4, 0, 4, 0};
    bit_scan_increment_jump_unit dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .pc_value(pc_value), .fetch_flush(fetch_flush)
    );
    axil_master_model mst_u (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] cmd(input int op, sr, m, d, b, t, f);
        return 32'(op) | 32'(sr) << 4 | 32'(m) << 8 | 32'(d) << 11 | 32'(b) << 15 | 32'(t) << 16 | 32'(f) << 17;
    endfunction : cmd
    // Returns the carry flag above the 16-bit scan result.
    function automatic logic [16:0] exp_scan(input int op, input logic [15:0] v);
        for (int k = 15; k >= 0; k--) begin
            if (op == 2 && v[k]) return {1'b0, 16'(16 - k)};
            if (op == 3 && v[15 - k]) return {1'b0, 16'(16 - k)};
            if (op == 1 && k < 15 && v[k] != v[15]) return {1'b0, 16'(k - 14)};
        end
        return (op == 1) ? {1'b1, 16'hFFF1} : {1'b1, 16'h0000};
    endfunction : exp_scan
    // Returns the status flags above the incremented word.
    function automatic logic [31:0] exp_inc(input logic [15:0] v, input logic b);
        logic [16:0] r;
        r = b ? 17'(v[7:0]) + 17'h0_0001 : 17'(v) + 17'h0_0001;
        if (b) return {7'h00, &v[3:0], 4'h0, r[7], v[7:0] == 8'h7F, r[7:0] == 8'h00, r[8], v[15:8], r[7:0]};
        return {7'h00, &v[7:0], 4'h0, r[15], v == 16'h7FFF, r[15:0] == 16'h0000, r[16], r[15:0]};
    endfunction : exp_inc
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        mst_u.wr(a, d, 4'hF, rr);
        check({30'h0, rr}, {30'h0, `RESP_OKAY});
    endtask : put
    task automatic errw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        mst_u.wr(a, d, st, rr);
        check({30'h0, rr}, {30'h0, `RESP_SLVERR});
    endtask : errw
    task automatic get(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        mst_u.rd(a, rv, rr);
        check(rv & m, x);
    endtask : get
    task automatic report_and_stop;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (aresetn === 1'b1 && fetch_flush === 1'b1) flush_cnt++;
        if (cyc == 30000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        get(`ADDR_PC, 32'h0000_0000, '1);
        get(8'h7C, 32'h0000_0000, '1);
        get(8'hA0, 32'h0000_0000, '1);
        check({30'h0, rr}, {30'h0, `RESP_SLVERR});
        errw(8'hB0, 32'h0000_0001, 4'hF);
        errw(`ADDR_CMD, cmd(2, 1, 0, 2, 0, 0, 0), 4'h3);
        errw(`ADDR_CMD, 32'h0000_0007, 4'hF);
        put(`ADDR_STATUS, 32'hFFFF_FFFF);
        get(`ADDR_STATUS, 32'h0000_010F, '1);
        for (int i = 0; i < 16; i++) begin
            w = (i < 8) ? corner[i] : 16'($random(seed));
            put(8'h44, {16'h0000, w});
            for (int op = 1; op <= 3; op++) begin
                put(`ADDR_CMD, cmd(op, 1, 0, 2, 0, 0, 0));
                s = exp_scan(op, w);
                get(8'h48, {16'h0000, s[15:0]}, '1);
                get(`ADDR_STATUS, {31'h0, s[16]}, 32'h0000_0001);
            end
        end
        mst_u.slow = 1'b1;
        put(8'h80, 32'h0000_0001);
        put(8'h84, 32'h0000_0010);
        put(8'h88, 32'h0000_0100);
        for (int m = 0; m < 6; m++) begin
            put(8'h4C, 32'h0000_0002);
            put(`ADDR_CMD, cmd(3, 3, m, 4, 0, 0, 0));
            get(8'h50, 32'(mres[m]), '1);
            get(8'h4C, 32'(mptr[m]), '1);
        end
        mst_u.slow = 1'b0;
        for (int i = 0; i < 8; i++) begin
            w = (i < 4) ? icorner[i] : 16'($random(seed));
            put(8'h94, {16'h0000, w});
            put(`ADDR_CMD, cmd(4, 0, 0, 0, i % 2, 1, 10));
            e = exp_inc(w, i[0]);
            get(8'h94, {16'h0000, e[15:0]}, '1);
            get(`ADDR_STATUS, {16'h0000, e[31:16]}, 32'h0000_010F);
            w = e[15:0];
            put(8'h40, {16'h0000, w});
            put(`ADDR_CMD, cmd(4, 0, 0, 0, i % 2, 0, 10));
            e = exp_inc(w, i[0]);
            get(8'h40, {16'h0000, e[15:0]}, '1);
            get(8'h94, {16'h0000, w}, '1);
        end
        for (int i = 0; i < 3; i++) begin
            lit = 23'($random(seed));
            put(`ADDR_JUMP_LIT, {9'h000, lit});
            fl0 = flush_cnt;
            put(`ADDR_CMD, cmd(5, 0, 0, 0, 0, 0, 0));
            get(`ADDR_PC, {9'h000, lit}, '1);
            check({9'h000, pc_value}, {9'h000, lit});
            check(32'(flush_cnt - fl0), 32'h0000_0001);
            put(`ADDR_PC, 32'h007F_FFFF);
            get(`ADDR_PC, 32'h007F_FFFF, '1);
            w = 16'($random(seed));
            put(8'h54, {16'h0000, w});
            put(`ADDR_CMD, cmd(6, 5, 0, 0, 0, 0, 0));
            get(`ADDR_PC, {16'h0000, w[15:1], 1'b0}, '1);
            check({9'h000, pc_value}, {16'h0000, w[15:1], 1'b0});
        end
        report_and_stop();
    end
endmodule : testbench
